// ---- hdl/lcd_pkg.sv ----
// constants and types for the multiplexed lcd segment pattern loader
// How it works
// - segment outputs pair up: 0/1 digit 1, 2/3 digit 2, 4/5 digit 3, 6/7 digit 4
// - digit 1 states 0-3 carry D,E,G,F and DP,C,B,A; 4-7 are complements
// - slave address 0x08; control byte 0xF4: 0x00 holds, 0x01 releases
// - bytes after one word address go to ascending successive state locations
// - bytes EB 59 01 97 14 A6 FE 68 show 1234
// - state n pattern byte sits at word address 0xD0 plus n
// - common k belongs to states k and k+4; halves have opposite polarity
// - while held low stay in reset; release restarts segments and commons together
package lcd_pkg;

  // ----------------------------------------------------------------
  // bus map
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR  = 7'h08;
  localparam logic [7:0] PAT_BASE    = 8'hD0;
  localparam logic [7:0] PAT_LAST    = 8'hD7;
  localparam logic [7:0] CTRL_ADDR   = 8'hF4;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam int         RUN_BIT     = 0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ      = 125000000;
  localparam int OSC_HZ      = 25000;
  localparam int STEP_CYCLES = CLK_HZ / OSC_HZ;

  // transfer phases of a write
  localparam logic [1:0] PH_ADDR = 2'h0;
  localparam logic [1:0] PH_WORD = 2'h1;
  localparam logic [1:0] PH_DATA = 2'h2;

  typedef enum logic [4:0] {
    I2C_IDLE = 5'h01,
    I2C_RECV = 5'h02,
    I2C_ACK  = 5'h04,
    I2C_SEND = 5'h08,
    I2C_MACK = 5'h10
  } i2c_state_t;

  typedef struct packed {
    logic       en;
    logic [2:0] addr;
    logic [7:0] data;
  } ram_wr_t;

  typedef struct packed {
    logic [3:0] comSelect;
    logic       comPolarity;
    logic [7:0] segments;
  } lcd_drive_t;

endpackage

// ---- hdl/pattern_ram.sv ----
// eight-byte pattern store, one write port and two registered read ports
`timescale 1ns/1ps
`default_nettype none
module pattern_ram (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire lcd_pkg::ram_wr_t wr,
  input  wire logic [2:0]       seqAddr,
  output logic      [7:0]       seqData,
  input  wire logic [2:0]       busAddr,
  output logic      [7:0]       busData
);

  logic [7:0] mem_q [0:7];
  logic [7:0] mem_d [0:7];

  // next contents: one byte replaced per write
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (wr.en) begin
      mem_d[wr.addr] = wr.data;
    end
  end

  // storage and read registers
  always_ff @(posedge clk) begin
    for (int i = 0; i < 8; i++) begin
      mem_q[i] <= rst ? 8'h00 : mem_d[i];
    end
    seqData <= rst ? 8'h00 : mem_q[seqAddr];
    busData <= rst ? 8'h00 : mem_q[busAddr];
  end

endmodule
`default_nettype wire

// ---- hdl/lcd_4mux_segment_pattern_loader.sv ----
// i2c-loaded eight-state segment pattern sequencer for a 4-mux lcd
`timescale 1ns/1ps
`default_nettype none
module lcd_4mux_segment_pattern_loader #(
  parameter int STEP_CYCLES = lcd_pkg::STEP_CYCLES
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         sclIn,
  input  wire logic         sdaIn,
  output logic              sdaOut,
  output logic              sdaOe,
  output lcd_pkg::lcd_drive_t drive
);

  // ----------------------------------------------------------------
  // pin synchronisers and bus events
  // ----------------------------------------------------------------
  logic [2:0] sclS_q;
  logic [2:0] sdaS_q;

  // three stages: only stage 1 reads stage 0
  always_ff @(posedge clk) begin
    sclS_q <= rst ? 3'h7 : {sclS_q[1:0], sclIn};
    sdaS_q <= rst ? 3'h7 : {sdaS_q[1:0], sdaIn};
  end

  logic sclRise;
  logic sclFall;
  logic busStart;
  logic busStop;
  logic sdaBit;

  assign sclRise  = sclS_q[1] & ~sclS_q[2];
  assign sclFall  = ~sclS_q[1] & sclS_q[2];
  assign busStart = sclS_q[1] & sclS_q[2] & sdaS_q[2] & ~sdaS_q[1];
  assign busStop  = sclS_q[1] & sclS_q[2] & ~sdaS_q[2] & sdaS_q[1];
  assign sdaBit   = sdaS_q[1];

  // ----------------------------------------------------------------
  // word address decode
  // ----------------------------------------------------------------
  function automatic logic isPattern(input logic [7:0] a);
    return (a >= lcd_pkg::PAT_BASE) && (a <= lcd_pkg::PAT_LAST);
  endfunction

  // ----------------------------------------------------------------
  // i2c slave
  // ----------------------------------------------------------------
  lcd_pkg::i2c_state_t st_q, st_d;
  logic [1:0] phase_q, phase_d;
  logic [3:0] bitCnt_q, bitCnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] ptr_q, ptr_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic       rw_q, rw_d;
  logic       mackOk_q, mackOk_d;
  logic [7:0] busData;
  logic [7:0] readByte;
  logic       byteDone;
  lcd_pkg::ram_wr_t wr;

  // what a read returns at the current pointer
  always_comb begin
    readByte = 8'h00;
    if (isPattern(ptr_q)) begin
      readByte = busData;
    end else if (ptr_q == lcd_pkg::CTRL_ADDR) begin
      readByte = ctrl_q;
    end
  end

  assign byteDone = (st_q == lcd_pkg::I2C_RECV) && sclFall &&
                    (bitCnt_q == 4'h8);

  // next state of the slave
  always_comb begin
    st_d     = st_q;
    phase_d  = phase_q;
    bitCnt_d = bitCnt_q;
    shift_d  = shift_q;
    ptr_d    = ptr_q;
    ctrl_d   = ctrl_q;
    rw_d     = rw_q;
    mackOk_d = mackOk_q;
    wr.en    = 1'b0;
    wr.addr  = ptr_q[2:0];
    wr.data  = shift_q;
    if (busStart) begin
      st_d     = lcd_pkg::I2C_RECV;
      phase_d  = lcd_pkg::PH_ADDR;
      bitCnt_d = 4'h0;
    end else if (busStop) begin
      st_d = lcd_pkg::I2C_IDLE;
    end else begin
      case (st_q)
        lcd_pkg::I2C_IDLE: begin
        end
        lcd_pkg::I2C_RECV: begin
          if (sclRise && bitCnt_q != 4'h8) begin
            shift_d  = {shift_q[6:0], sdaBit};
            bitCnt_d = bitCnt_q + 4'h1;
          end
          if (byteDone) begin
            st_d = lcd_pkg::I2C_ACK;
            case (phase_q)
              lcd_pkg::PH_ADDR: begin
                rw_d    = shift_q[0];
                phase_d = lcd_pkg::PH_WORD;
                if (shift_q[7:1] != lcd_pkg::SLAVE_ADDR) begin
                  st_d = lcd_pkg::I2C_IDLE;
                end
              end
              lcd_pkg::PH_WORD: begin
                ptr_d   = shift_q;
                phase_d = lcd_pkg::PH_DATA;
              end
              default: begin
                wr.en = isPattern(ptr_q);
                if (ptr_q == lcd_pkg::CTRL_ADDR) begin
                  ctrl_d = shift_q;
                end
                ptr_d = ptr_q + 8'h01;
              end
            endcase
          end
        end
        lcd_pkg::I2C_ACK: begin
          if (sclFall) begin
            bitCnt_d = 4'h0;
            if (rw_q) begin
              st_d    = lcd_pkg::I2C_SEND;
              shift_d = readByte;
              ptr_d   = ptr_q + 8'h01;
            end else begin
              st_d = lcd_pkg::I2C_RECV;
            end
          end
        end
        lcd_pkg::I2C_SEND: begin
          if (sclRise) begin
            bitCnt_d = bitCnt_q + 4'h1;
          end
          if (sclFall) begin
            if (bitCnt_q == 4'h8) begin
              st_d = lcd_pkg::I2C_MACK;
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
            end
          end
        end
        lcd_pkg::I2C_MACK: begin
          if (sclRise) begin
            mackOk_d = ~sdaBit;
          end
          if (sclFall) begin
            bitCnt_d = 4'h0;
            if (mackOk_q) begin
              st_d    = lcd_pkg::I2C_SEND;
              shift_d = readByte;
              ptr_d   = ptr_q + 8'h01;
            end else begin
              st_d = lcd_pkg::I2C_IDLE;
            end
          end
        end
        default: st_d = lcd_pkg::I2C_IDLE;
      endcase
    end
  end

  // slave registers
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q     <= lcd_pkg::I2C_IDLE;
      phase_q  <= lcd_pkg::PH_ADDR;
      bitCnt_q <= 4'h0;
      shift_q  <= 8'h00;
      ptr_q    <= 8'h00;
      ctrl_q   <= lcd_pkg::CTRL_RESET;
      rw_q     <= 1'b0;
      mackOk_q <= 1'b0;
    end else begin
      st_q     <= st_d;
      phase_q  <= phase_d;
      bitCnt_q <= bitCnt_d;
      shift_q  <= shift_d;
      ptr_q    <= ptr_d;
      ctrl_q   <= ctrl_d;
      rw_q     <= rw_d;
      mackOk_q <= mackOk_d;
    end
  end

  // open-drain data pin: only ever pulls low
  assign sdaOut = 1'b0;
  assign sdaOe  = (st_q == lcd_pkg::I2C_ACK) ||
                  ((st_q == lcd_pkg::I2C_SEND) && !shift_q[7]);

  // ----------------------------------------------------------------
  // pattern sequencer
  // ----------------------------------------------------------------
  logic        run;
  logic        step;
  logic [12:0] stepCnt_q, stepCnt_d;
  logic [2:0]  seqState_q, seqState_d;
  logic [7:0]  seqData;

  assign run  = ctrl_q[lcd_pkg::RUN_BIT];
  assign step = run && (stepCnt_q == 13'(STEP_CYCLES - 1));

  // one shared tick drives both segment and common timing
  always_comb begin
    stepCnt_d  = stepCnt_q + 13'h0001;
    seqState_d = seqState_q;
    if (!run) begin
      stepCnt_d  = 13'h0000;
      seqState_d = 3'h0;
    end else if (step) begin
      stepCnt_d  = 13'h0000;
      seqState_d = seqState_q + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    stepCnt_q  <= rst ? 13'h0000 : stepCnt_d;
    seqState_q <= rst ? 3'h0 : seqState_d;
  end

  // read address leads by one so data lines up with the state
  pattern_ram ram (
    .clk     (clk),
    .rst     (rst),
    .wr      (wr),
    .seqAddr (seqState_d),
    .seqData (seqData),
    .busAddr (ptr_q[2:0]),
    .busData (busData)
  );

  // segment pairs per digit follow bit order of the state byte
  always_comb begin
    drive.segments    = run ? seqData : 8'h00;
    drive.comSelect   = run ? (4'h1 << seqState_q[1:0]) : 4'h0;
    drive.comPolarity = run & seqState_q[2];
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_addr_match: assert property (byteDone && phase_q == lcd_pkg::PH_ADDR &&
      shift_q[7:1] == lcd_pkg::SLAVE_ADDR |=> st_q == lcd_pkg::I2C_ACK ##1
      sdaOe) else $error("own address not acknowledged");
  a_addr_other: assert property (byteDone && phase_q == lcd_pkg::PH_ADDR &&
      shift_q[7:1] != lcd_pkg::SLAVE_ADDR |=> st_q == lcd_pkg::I2C_IDLE)
      else $error("foreign address taken");
  a_ctrl_write: assert property (byteDone && phase_q == lcd_pkg::PH_DATA &&
      ptr_q == lcd_pkg::CTRL_ADDR |=> ctrl_q == $past(shift_q))
      else $error("control byte not stored");
  a_wr_index: assert property (wr.en |-> isPattern(ptr_q) &&
      wr.addr == 3'(ptr_q - lcd_pkg::PAT_BASE))
      else $error("pattern write to wrong state");
  a_wr_ascend: assert property (wr.en |=> ptr_q == $past(ptr_q) + 8'h01)
      else $error("pointer did not advance");
  a_state_step: assert property (step |=> seqState_q ==
      $past(seqState_q) + 3'h1) else $error("state did not advance");
  a_hold_zero: assert property (!run |-> drive.segments == 8'h00 &&
      drive.comSelect == 4'h0 ##1 seqState_q == 3'h0 &&
      stepCnt_q == 13'h0000)
      else $error("held sequencer not idle");
  a_first_state: assert property ($rose(run) |-> seqState_q == 3'h0 ##1
      seqState_q == 3'h0) else $error("release not at state 0");
  a_com_pair: assert property (run && $past(run) && $stable(seqState_q)
      |-> drive.comSelect == $past(drive.comSelect))
      else $error("common moved without a step");
  a_seg_match: assert property (run && $stable(seqState_q) &&
      !$past(wr.en) && !$past(wr.en, 2)
      |-> drive.segments == $past(seqData))
      else $error("segments not the state byte");

  c_release: cover property ($rose(run));
  c_wrap: cover property (step && seqState_q == 3'h7);
  c_read: cover property (st_q == lcd_pkg::I2C_MACK && sclFall && mackOk_q);
  c_show_first: cover property (run && seqState_q == 3'h0 &&
      drive.segments == 8'hEB);

endmodule
`default_nettype wire

// ---- testbench/i2c_master_model.sv ----
// i2c master model that loads and reads the pattern loader
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sdaLow
);
  // bus idles released, both lines pulled high
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  // wait a number of system clocks
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one bit slot, data set mid low phase, wire sampled late in high
  task automatic bitSlot(input logic b, output logic r);
    scl <= 1'b0;
    tk(2);
    sdaLow <= !b;
    tk(2);
    scl <= 1'b1;
    tk(3);
    @(negedge clk);
    r = sda;
    tk(1);
  endtask

  // start, also usable as repeated start
  task automatic start();
    scl <= 1'b0;
    tk(2);
    sdaLow <= 1'b0;
    tk(2);
    scl <= 1'b1;
    tk(4);
    sdaLow <= 1'b1;
    tk(4);
  endtask

  // stop: sda rises while scl high, then bus stands idle
  task automatic stop();
    scl <= 1'b0;
    tk(2);
    sdaLow <= 1'b1;
    tk(2);
    scl <= 1'b1;
    tk(4);
    sdaLow <= 1'b0;
    tk(4);
  endtask

  // eight bits msb first plus acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ab,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bitSlot(d[i], q[i]);
    end
    bitSlot(ab, ack);
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb_lcd_4mux_segment_pattern_loader.sv ----
// self-checking bench for the lcd segment pattern loader
`timescale 1ns/1ps
`default_nettype none
module tb_lcd_4mux_segment_pattern_loader;
  localparam int STEP = 16;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                scl;
  logic                sdaLow;
  logic                sdaOut;
  logic                sdaOe;
  logic                sda;
  lcd_pkg::lcd_drive_t drive;
  int                  mismatches = 0;
  int                  total_checks = 0;
  logic [7:0]          pat [8];
  logic [7:0]          ctlv = 8'h00;
  logic [7:0]          q;
  logic                ack;

  // clock and open-drain wire with pull-up
  always #4 clk = ~clk;
  assign sda = !(sdaLow | (sdaOe & !sdaOut));

  lcd_4mux_segment_pattern_loader #(.STEP_CYCLES(STEP)) uut (
    .clk(clk), .rst(rst), .sclIn(scl), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .drive(drive));
  i2c_master_model m (.clk(clk), .sda(sda), .scl(scl), .sdaLow(sdaLow));

  // compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // verdict and end of run
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // expected read data of a word address
  function automatic logic [7:0] memExp(input logic [7:0] a);
    if (a >= 8'hD0 && a <= 8'hD7) return pat[a[2:0]];
    if (a == lcd_pkg::CTRL_ADDR) return ctlv;
    return 8'h00;
  endfunction

  // expected common select and polarity of step s
  function automatic logic [4:0] comExp(input int s);
    return {4'h1 << (s % 4), (s % 8) >= 4};
  endfunction

  // write n bytes from word address a
  task automatic wr(input logic [7:0] a, input int n,
                    input logic [7:0] d [8]);
    m.start();
    m.xfer(8'h10, 1'b1, q, ack);
    check(ack, 1'b0);
    m.xfer(a, 1'b1, q, ack);
    check(ack, 1'b0);
    for (int i = 0; i < n; i++) begin
      m.xfer(d[i], 1'b1, q, ack);
      check(ack, 1'b0);
    end
    m.stop();
  endtask

  // write the control byte
  task automatic ctl(input logic [7:0] v);
    logic [7:0] b [8];
    b[0] = v;
    ctlv = v;
    wr(lcd_pkg::CTRL_ADDR, 1, b);
  endtask

  // set word address, repeated start, read n bytes
  task automatic rd(input logic [7:0] a, input int n);
    m.start();
    m.xfer(8'h10, 1'b1, q, ack);
    m.xfer(a, 1'b1, q, ack);
    m.start();
    m.xfer(8'h11, 1'b1, q, ack);
    check(ack, 1'b0);
    for (int i = 0; i < n; i++) begin
      m.xfer(8'hFF, i == n - 1, q, ack);
      check(q, memExp(a + 8'(i)));
    end
    m.stop();
  endtask

  // release the sequencer and follow three frames
  task automatic runCheck();
    fork
      ctl(8'h01);
      begin
        for (int k = 0; k < 2000 && drive.comSelect === 4'h0; k++)
          @(negedge clk);
        check(drive.comSelect, 4'h1);
        repeat (STEP / 2) @(negedge clk);
        for (int i = 0; i < 24; i++) begin
          check(drive.segments, pat[i % 8]);
          check({drive.comSelect, drive.comPolarity}, comExp(i));
          repeat (STEP) @(negedge clk);
        end
      end
    join
  endtask

  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    test_done();
  end

  // main sequence
  initial begin
    void'($urandom(72));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    check(drive, 13'h0);
    pat = '{8'hEB, 8'h59, 8'h01, 8'h97, 8'h14, 8'hA6, 8'hFE, 8'h68};
    for (int r = 0; r < 4; r++) begin
      ctl(8'h00);
      check(drive, 13'h0);
      wr(lcd_pkg::PAT_BASE, 8, pat);
      runCheck();
      rd(8'hD5, 5);
      rd(lcd_pkg::CTRL_ADDR, 1);
      for (int s = 0; s < 4; s++) begin
        pat[s] = 8'($urandom);
        pat[s + 4] = ~pat[s];
      end
    end
    wr(8'hE0, 1, pat);
    rd(8'hE0, 1);
    m.start();
    m.xfer(8'h12, 1'b1, q, ack);
    check(ack, 1'b1);
    m.stop();
    // reset in mid-run: outputs and control byte return to held
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check(drive, 13'h0);
    check(sdaOut, 1'b0);
    @(posedge clk);
    ctlv = 8'h00;
    pat = '{default: 8'h00};
    rd(lcd_pkg::CTRL_ADDR, 1);
    rd(lcd_pkg::PAT_BASE, 2);
    test_done();
  end
endmodule
`default_nettype wire
